// >>> rtl/exec_pkg.sv
// constants and types for the six-instruction execution block
// assumes a 21-bit byte program counter and 12-bit data addresses
package exec_pkg;

    localparam int PC_W = 21;
    localparam int DA_W = 12;

    // apb register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_FLAGS = 8'h04;
    localparam logic [7:0] REG_WORK = 8'h08;
    localparam logic [7:0] REG_BANK = 8'h0C;
    localparam logic [7:0] REG_SHADOW = 8'h10;
    localparam logic [7:0] REG_PC = 8'h14;

    // flag bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_N = 4;
    // status bit positions in the flags register
    localparam int STAT_PD = 5;
    localparam int STAT_TO = 6;

    // opcode fields
    localparam logic [3:0] OP_TOGGLE = 4'h7;
    localparam logic [7:0] OP_BOV = 8'hE4;
    localparam logic [7:0] OP_BZ = 8'hE0;
    localparam logic [6:0] OP_CALL = 7'h76;
    localparam logic [6:0] OP_CLEAR = 7'h35;
    localparam logic [15:0] OP_WDT = 16'h0004;
    localparam logic [3:0] ACCESS_BANK = 4'h0;

    // reset values and steps
    localparam logic [15:0] IR_RST = 16'h0000;
    localparam logic [PC_W-1:0] PC_RST = 21'h0;
    localparam logic [PC_W-1:0] PC_STEP = 21'h2;
    localparam logic [4:0] FLAGS_RST = 5'h0;
    localparam logic [7:0] CLEAR_VALUE = 8'h00;
    localparam logic [3:0] QUARTER_RST = 4'h1;

    typedef enum logic {exec_cycle, nop_cycle} cycle_t;

endpackage : exec_pkg

// >>> rtl/quarter_phase.sv
// quarter-cycle sequencer: four pclk cycles make one instruction cycle
// assumes one free-running clock and asynchronous active-low reset
`timescale 1ns/1ps
module quarter_phase
    import exec_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    output logic [3:0] q_en
);

    // one-hot ring, bit 0 marks the decode quarter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_en <= QUARTER_RST;
        end else begin
            q_en <= {q_en[2:0], q_en[3]};
        end
    end

endmodule : quarter_phase

// >>> rtl/bit_branch_call_clear_exec.sv
// execution of bit toggle, two branches, call, clear and watchdog clear
// assumes combinational program and data memory reads on pclk,
// and a watchdog and return stack that act on one-cycle strobes.
//
// Function
// RL1 - a=0 selects fixed low bank; a=1 uses bank pointer register
// RL2 - toggle inverts exactly selected bit, leaves flags alone
// RL3 - branch-on-overflow branches only when overflow flag is one
// RL4 - taken branch loads incremented pc plus twice signed offset
// RL5 - branch takes one cycle untaken, two when taken
// RL6 - branch-on-zero branches only when zero flag is one
// RL7 - call pushes address after its two words onto return stack
// RL8 - call with save bit copies working, flags, bank into shadows
// RL9 - call without save bit leaves shadows unchanged
// RL10 - call target is 20 bits from both words, loaded into pc 20:1
// RL11 - call takes two words and two cycles, second a no-op
// RL12 - clear writes zero to addressed register and sets zero flag
// RL13 - watchdog clear zeroes the watchdog count in one cycle
// RL14 - watchdog clear also zeroes the postscaler count
// RL15 - watchdog clear sets timeout and power-down status bits
// RL16 - instructions naming no flag leave all flags unchanged
// RL17 - read operand in quarter two, process three, write four
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module bit_branch_call_clear_exec
    import exec_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [PC_W-1:0] pm_addr,
    input wire logic [15:0] pm_data,
    output logic [DA_W-1:0] dm_addr,
    output logic [7:0] dm_wdata,
    output logic dm_we,
    input wire logic [7:0] dm_rdata,
    output logic rs_push,
    output logic [PC_W-1:0] rs_data,
    output logic watchdog_counter_clr,
    output logic watchdog_post_clr,
    input wire logic watchdog_timeout_evt,
    input wire logic sleep_evt,
    output logic timeout_status_n,
    output logic power_down_status_n
);

    // ------------------------------------------------------------
    // quarter sequencing and decode
    // ------------------------------------------------------------
    logic [3:0] q_en;
    logic q1;
    logic q2;
    logic q3;
    logic q4;
    logic run;
    cycle_t state;
    logic [15:0] ir;
    logic [7:0] opnd;
    logic [4:0] flags;
    logic [7:0] working_reg;
    logic [3:0] bank_pointer_reg;
    logic [7:0] working_shadow;
    logic [4:0] flags_shadow;
    logic [3:0] bank_pointer_shadow;
    logic live;
    logic is_toggle;
    logic is_clear;
    logic is_bov;
    logic is_bz;
    logic is_call;
    logic is_wdt;
    logic taken;
    logic apb_wr;
    logic [31:0] next_prdata;
    logic next_pslverr;

    quarter_phase u_phase (
        .pclk(pclk),
        .presetn(presetn),
        .q_en(q_en)
    );

    assign q1 = q_en[0];
    assign q2 = q_en[1];
    assign q3 = q_en[2];
    assign q4 = q_en[3];

    function automatic logic [DA_W-1:0] data_addr(input logic [15:0] w, input logic [3:0] bank);
        data_addr = w[8] ? {bank, w[7:0]} : {ACCESS_BANK, w[7:0]};
    endfunction : data_addr

    function automatic logic [PC_W-1:0] branch_step(input logic [7:0] n);
        branch_step = {{12{n[7]}}, n, 1'b0};
    endfunction : branch_step

    assign live = run && (state == exec_cycle);
    assign is_toggle = (ir[15:12] == OP_TOGGLE);
    assign is_clear = (ir[15:9] == OP_CLEAR);
    assign is_bov = (ir[15:8] == OP_BOV);
    assign is_bz = (ir[15:8] == OP_BZ);
    assign is_call = (ir[15:9] == OP_CALL);
    assign is_wdt = (ir == OP_WDT);
    assign taken = (is_bov && flags[FLAG_OV]) || (is_bz && flags[FLAG_Z]); // see RL3 see RL6
    assign apb_wr = psel && penable && pready && pwrite;

    // ------------------------------------------------------------
    // data memory path
    // ------------------------------------------------------------
    // address settles in the decode quarter so the read is stable in quarter two
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dm_addr <= '0;
        end else if (q1 && live) begin
            dm_addr <= data_addr(ir, bank_pointer_reg); // see RL1
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opnd <= '0;
        end else if (q2 && live) begin
            opnd <= dm_rdata; // see RL17
        end
    end

    // strobe stands for the whole write quarter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dm_we <= 1'b0;
            dm_wdata <= '0;
        end else begin
            dm_we <= q3 && live && (is_toggle || is_clear); // see RL17
            if (q3 && live) begin
                if (is_clear) begin
                    dm_wdata <= CLEAR_VALUE; // see RL12
                end else begin
                    dm_wdata <= opnd ^ (8'h01 << ir[11:9]); // see RL2
                end
            end
        end
    end

    // ------------------------------------------------------------
    // return stack and program counter
    // ------------------------------------------------------------
    // pc already points past the first word, so one more step skips both
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rs_push <= 1'b0;
            rs_data <= PC_RST;
        end else begin
            rs_push <= q2 && live && is_call; // see RL7
            if (q2 && live && is_call) begin
                rs_data <= pm_addr + PC_STEP; // see RL7
            end
        end
    end

    // the word fetched behind a redirect is dropped by the no-op cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pm_addr <= PC_RST;
            ir <= IR_RST;
            state <= nop_cycle;
        end else if (q4 && run) begin
            case (state)
                exec_cycle: begin
                    if (taken) begin
                        pm_addr <= pm_addr + branch_step(ir[7:0]); // see RL4
                        state <= nop_cycle; // see RL5
                    end else if (is_call) begin
                        pm_addr <= {pm_data[11:0], ir[7:0], 1'b0}; // see RL10
                        state <= nop_cycle; // see RL11
                    end else begin
                        ir <= pm_data;
                        pm_addr <= pm_addr + PC_STEP; // see RL5
                    end
                end
                nop_cycle: begin
                    ir <= pm_data;
                    pm_addr <= pm_addr + PC_STEP;
                    state <= exec_cycle;
                end
                default: begin
                    state <= nop_cycle;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // flags, working registers and shadows
    // ------------------------------------------------------------
    // the core's own update wins over a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= FLAGS_RST;
        end else if (q4 && live && is_clear) begin
            flags[FLAG_Z] <= 1'b1; // see RL12 see RL16
        end else if (apb_wr && paddr == REG_FLAGS) begin
            flags <= pwdata[4:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            working_reg <= '0;
            bank_pointer_reg <= '0;
            run <= 1'b0;
        end else if (apb_wr) begin
            if (paddr == REG_WORK) begin
                working_reg <= pwdata[7:0];
            end
            if (paddr == REG_BANK) begin
                bank_pointer_reg <= pwdata[3:0];
            end
            if (paddr == REG_CTRL) begin
                run <= pwdata[0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            working_shadow <= '0;
            flags_shadow <= FLAGS_RST;
            bank_pointer_shadow <= '0;
        end else if (q4 && live && is_call && ir[8]) begin // see RL8 see RL9
            working_shadow <= working_reg;
            flags_shadow <= flags;
            bank_pointer_shadow <= bank_pointer_reg;
        end
    end

    // ------------------------------------------------------------
    // watchdog strobes and status
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_counter_clr <= 1'b0;
            watchdog_post_clr <= 1'b0;
        end else begin
            watchdog_counter_clr <= q4 && live && is_wdt; // see RL13
            watchdog_post_clr <= q4 && live && is_wdt; // see RL14
        end
    end

    // setting by the instruction beats a clearing event in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_status_n <= 1'b1;
            power_down_status_n <= 1'b1;
        end else if (q4 && live && is_wdt) begin
            timeout_status_n <= 1'b1; // see RL15
            power_down_status_n <= 1'b1; // see RL15
        end else begin
            if (watchdog_timeout_evt) begin
                timeout_status_n <= 1'b0;
            end
            if (sleep_evt) begin
                power_down_status_n <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // apb slave, one wait-free access phase
    // ------------------------------------------------------------
    always_comb begin
        next_prdata = '0;
        next_pslverr = 1'b0;
        case (paddr)
            REG_CTRL: next_prdata = {31'h0, run};
            REG_FLAGS: next_prdata = {25'h0, timeout_status_n, power_down_status_n, flags};
            REG_WORK: next_prdata = {24'h000000, working_reg};
            REG_BANK: next_prdata = {28'h0000000, bank_pointer_reg};
            REG_SHADOW: next_prdata = {12'h000, bank_pointer_shadow, 3'h0, flags_shadow, working_shadow};
            REG_PC: next_prdata = {11'h0, pm_addr};
            default: next_pslverr = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            if (psel && !penable) begin
                prdata <= pwrite ? 32'h00000000 : next_prdata;
                pslverr <= next_pslverr;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence redirect_hold;
        state == nop_cycle && !dm_we;
    endsequence

    a_bank_addr_select: assert property (q1 && live |=> dm_addr == data_addr($past(ir), $past(bank_pointer_reg))) // see RL1
        else $error("data address ignores bank select");

    a_toggle_one_bit: assert property (dm_we && is_toggle |-> dm_wdata == (opnd ^ (8'h01 << ir[11:9]))) // see RL2
        else $error("toggle wrote wrong value");

    a_branch_taken_pc: assert property (q4 && live && taken |=> redirect_hold ##0 // see RL4
        pm_addr == $past(pm_addr) + branch_step($past(ir[7:0])))
        else $error("taken branch target wrong");

    a_branch_untaken_pc: assert property (q4 && live && (is_bov || is_bz) && !taken |=> // see RL5
        state == exec_cycle && pm_addr == $past(pm_addr) + PC_STEP)
        else $error("untaken branch redirected");

    a_flag_gates_branch: assert property (q4 && live && ((is_bov && !flags[FLAG_OV]) || (is_bz && !flags[FLAG_Z])) // see RL3
        |=> state == exec_cycle)
        else $error("branch taken without flag");

    a_call_push_addr: assert property (q2 && live && is_call |=> rs_push && rs_data == $past(pm_addr) + PC_STEP) // see RL7
        else $error("call pushed wrong return address");

    a_call_target_pc: assert property (q4 && live && is_call |=> redirect_hold ##0 // see RL10
        pm_addr == {$past(pm_data[11:0]), $past(ir[7:0]), 1'b0})
        else $error("call target wrong");

    a_shadow_save: assert property (q4 && live && is_call && ir[8] |=> // see RL8
        working_shadow == $past(working_reg) && bank_pointer_shadow == $past(bank_pointer_reg))
        else $error("shadow save missed");

    a_shadow_keep: assert property (q4 && live && is_call && !ir[8] |=> $stable(flags_shadow) && // see RL9
        $stable(working_shadow) && $stable(bank_pointer_shadow))
        else $error("shadows changed without save bit");

    a_clear_zero_flag: assert property (q4 && live && is_clear |-> dm_we && dm_wdata == CLEAR_VALUE // see RL12
        ##1 flags[FLAG_Z])
        else $error("clear failed");

    a_flags_untouched: assert property (q4 && live && !is_clear && !apb_wr |=> flags == $past(flags)) // see RL16
        else $error("flags changed by flagless instruction");

    a_watchdog_clear: assert property (q4 && live && is_wdt |=> watchdog_counter_clr && watchdog_post_clr // see RL13
        && timeout_status_n && power_down_status_n ##1 !watchdog_counter_clr)
        else $error("watchdog clear strobe wrong");

    a_write_quarter_four: assert property (dm_we |-> q4 && $past(q3, 1)) // see RL17
        else $error("write outside quarter four");

endmodule : bit_branch_call_clear_exec

// >>> tb/exec_partner.sv
// far side of the execution block: program store, data store, return stack, watchdog
// assumes combinational memory reads and one-pclk strobes from the block
`timescale 1ns/1ps
module exec_partner
    import exec_pkg::*;
(
    input wire logic pclk,
    input wire logic [PC_W-1:0] pm_addr,
    output logic [15:0] pm_data,
    input wire logic [DA_W-1:0] dm_addr,
    input wire logic [7:0] dm_wdata,
    input wire logic dm_we,
    output logic [7:0] dm_rdata,
    input wire logic rs_push,
    input wire logic [PC_W-1:0] rs_data,
    input wire logic watchdog_counter_clr,
    input wire logic watchdog_post_clr
);
    // -----------------------------------------------------------------
    // storage and strobe counters
    // -----------------------------------------------------------------
    // program store aliases on pc bits 8:1; high target bits show on pm_addr only
    logic [15:0] pmem [256] = '{default: 16'h0000};
    logic [7:0] dmem [4096] = '{default: 8'h00};
    logic [PC_W-1:0] pushes [$];
    int n_wclr = 0;
    int n_pclr = 0;

    assign pm_data = pmem[pm_addr[8:1]];
    assign dm_rdata = dmem[dm_addr];

    always @(posedge pclk) begin
        if (dm_we)
            dmem[dm_addr] <= dm_wdata;
        if (rs_push)
            pushes.push_back(rs_data);
        if (watchdog_counter_clr)
            n_wclr <= n_wclr + 1;
        if (watchdog_post_clr)
            n_pclr <= n_pclr + 1;
    end
endmodule : exec_partner

// >>> tb/bit_branch_call_clear_exec_bench.sv
// self-checking bench: one short program run through the execution block in two stretches
// assumes exec_partner as far side and the register map of exec_pkg
`timescale 1ns/1ps
module bit_branch_call_clear_exec_bench
    import exec_pkg::*;
;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [PC_W-1:0] pm_addr;
    logic [15:0] pm_data;
    logic [DA_W-1:0] dm_addr;
    logic [7:0] dm_wdata;
    logic dm_we;
    logic [7:0] dm_rdata;
    logic rs_push;
    logic [PC_W-1:0] rs_data;
    logic wclr;
    logic pclr;
    logic timeout_status_n;
    logic power_down_status_n;
    logic watchdog_timeout_evt = 1'h0;
    logic sleep_evt = 1'h0;
    logic [31:0] rd;
    logic err;
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;
    int stamp [logic [PC_W-1:0]];

    bit_branch_call_clear_exec i_bit_branch_call_clear_exec (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pm_addr(pm_addr), .pm_data(pm_data), .dm_addr(dm_addr), .dm_wdata(dm_wdata),
        .dm_we(dm_we), .dm_rdata(dm_rdata), .rs_push(rs_push), .rs_data(rs_data), .watchdog_counter_clr(wclr),
        .watchdog_post_clr(pclr), .watchdog_timeout_evt(watchdog_timeout_evt), .sleep_evt(sleep_evt),
        .timeout_status_n(timeout_status_n), .power_down_status_n(power_down_status_n));

    exec_partner i_exec_partner (.pclk(pclk), .pm_addr(pm_addr), .pm_data(pm_data), .dm_addr(dm_addr),
        .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_rdata(dm_rdata), .rs_push(rs_push), .rs_data(rs_data),
        .watchdog_counter_clr(wclr), .watchdog_post_clr(pclr));

    always #4 pclk = ~pclk;

    // first cycle each fetch address shows up, for cycle-count checks
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (!stamp.exists(pm_addr))
            stamp[pm_addr] = cyc;
    end

    // -----------------------------------------------------------------
    // tasks
    // -----------------------------------------------------------------
    task automatic finish_test;
        $display("compares %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test

    task automatic hang(input logic stuck);
        if (stuck) begin
            $display("[ERR] %0t wait ran out", $time);
            err_total++;
            finish_test();
        end
    endtask : hang

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        hang(pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic run_until(input logic [PC_W-1:0] addr);
        int n = 0;
        apb(1'h1, REG_CTRL, 32'h1);
        while (pm_addr !== addr && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        hang(pm_addr !== addr);
        apb(1'h1, REG_CTRL, 32'h0);
    endtask : run_until

    task automatic pm(input logic [7:0] i, input logic [15:0] w);
        i_exec_partner.pmem[i] = w;
    endtask : pm

    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        pm(8'h00, {OP_TOGGLE, 3'h4, 1'h0, 8'h20});
        pm(8'h01, {OP_TOGGLE, 3'h7, 1'h1, 8'h40});
        pm(8'h02, {OP_BOV, 8'h01});
        pm(8'h03, {OP_BZ, 8'h01});
        pm(8'h04, {OP_CLEAR, 1'h1, 8'h41});
        pm(8'h05, {OP_BZ, 8'h01});
        pm(8'h06, {OP_TOGGLE, 3'h0, 1'h0, 8'h21});
        pm(8'h07, {OP_CALL, 1'h1, 8'h10});
        pm(8'h08, {4'hF, 12'h810});
        pm(8'h10, OP_WDT);
        pm(8'h11, {OP_BZ, 8'hFF});
        pm(8'h12, {OP_BOV, 8'h02});
        pm(8'h13, {OP_TOGGLE, 3'h0, 1'h0, 8'h22});
        pm(8'h14, {OP_TOGGLE, 3'h1, 1'h0, 8'h22});
        pm(8'h15, {OP_CALL, 1'h0, 8'h19});
        pm(8'h16, {4'hF, 12'h810});
        pm(8'h18, {OP_BOV, 8'h08});
        pm(8'h19, {OP_BOV, 8'hFD});
        pm(8'h21, {OP_BOV, 8'hFF});
        i_exec_partner.dmem[12'h020] = 8'h75;
        i_exec_partner.dmem[12'h021] = 8'h99;
        i_exec_partner.dmem[12'h022] = 8'h5C;
        i_exec_partner.dmem[12'h040] = 8'h33;
        i_exec_partner.dmem[12'h340] = 8'h0F;
        i_exec_partner.dmem[12'h341] = 8'hAA;
        apb(1'h1, REG_BANK, 32'h3);
        apb(1'h1, REG_WORK, 32'h5A);
        apb(1'h1, REG_FLAGS, 32'h11);
        @(posedge pclk);
        watchdog_timeout_evt <= 1'h1;
        sleep_evt <= 1'h1;
        @(posedge pclk);
        watchdog_timeout_evt <= 1'h0;
        sleep_evt <= 1'h0;
        apb(1'h0, REG_FLAGS, 32'h0);
        check(rd, 32'h11);
        check(timeout_status_n, 1'h0);
        check(power_down_status_n, 1'h0);
        apb(1'h0, 8'h20, 32'h0);
        check(rd, 32'h0);
        check(err, 1'h1);
        run_until(21'h102024);
        check(i_exec_partner.dmem[12'h020], 8'h65);
        check(i_exec_partner.dmem[12'h340], 8'h8F);
        check(i_exec_partner.dmem[12'h040], 8'h33);
        check(i_exec_partner.dmem[12'h341], 8'h00);
        check(i_exec_partner.dmem[12'h021], 8'h99);
        check(stamp[21'h08] - stamp[21'h06], 32'h4);
        check(stamp[21'h0A] - stamp[21'h08], 32'h4);
        check(stamp[21'h10] - stamp[21'h0C], 32'h8);
        check(stamp.exists(21'h0E), 1'h1);
        check(stamp[21'h102022] - stamp[21'h10], 32'h8);
        check(stamp.exists(21'h102020), 1'h1);
        check(i_exec_partner.pushes[0], 21'h12);
        check(i_exec_partner.n_wclr, 32'h1);
        check(i_exec_partner.n_pclr, 32'h1);
        apb(1'h0, REG_FLAGS, 32'h0);
        check(rd, 32'h75);
        check(timeout_status_n, 1'h1);
        check(power_down_status_n, 1'h1);
        apb(1'h0, REG_SHADOW, 32'h0);
        check(rd, 32'h0003155A);
        stamp.delete();
        apb(1'h1, REG_WORK, 32'hC3);
        apb(1'h1, REG_BANK, 32'h5);
        apb(1'h1, REG_FLAGS, 32'h08);
        run_until(21'h102044);
        check(stamp[21'h10202C] - stamp[21'h102026], 32'h8);
        check(stamp.exists(21'h10202E), 1'h1);
        check(i_exec_partner.dmem[12'h022], 8'h5C);
        check(i_exec_partner.pushes.size(), 32'h2);
        check(i_exec_partner.pushes[1], 21'h10202E);
        apb(1'h0, REG_SHADOW, 32'h0);
        check(rd, 32'h0003155A);
        apb(1'h0, REG_FLAGS, 32'h0);
        check(rd, 32'h68);
        apb(1'h0, REG_PC, 32'h0);
        check((rd == 32'h00102042) || (rd == 32'h00102044), 1'h1);
        finish_test();
    end
endmodule : bit_branch_call_clear_exec_bench
